/* bench/smpc_stop_ctrl_tb.sv */
// Purpose: self-checking bench for the stop-mode power controller
// Assumes: inputs change on the falling edge; short periodic tick
// Notes:   one task per scenario; pulses gathered in a sticky vector
`timescale 1ns/1ps

module smpc_stop_ctrl_tb
  import smpc_pkg::*;
  ;
  localparam int CLK_NS    = 40;
  localparam int WD_CYCLES = 5000;
  logic clk = 1'b0, rst_n = 1'b0, stop_exec = 1'b0, stop_allow = 1'b1;
  logic powerdown_select = 1'b0, partial_powerdown_select = 1'b0, lowvolt_reset_enable = 1'b0;
  logic debug_mode_enable = 1'b0, debug_status_command = 1'b0, debug_halt_command = 1'b0;
  logic [RATE_W-1:0] periodic_wake_rate_select = RATE_OFF;
  logic external_request_enable = 1'b1, external_request_active_high = 1'b0, keypad_active_high = 1'b0;
  logic [KB_W-1:0] keypad_group_a_enable = 8'h01, keypad_group_b_enable = 8'h01;
  logic pull_ext = 1'b0, pull_kba = 1'b0, pull_kbb = 1'b0, pull_rst = 1'b0;
  logic reset_pin_n, external_request_pin, partial_powerdown_ack;
  logic [KB_W-1:0] keypad_wake_group_a, keypad_wake_group_b;
  logic [1:0] stop_state;
  logic core_power_on, ram_power_on, regulator_standby, oscillator_run, debug_clock_run, peripheral_clock_run;
  logic analog_comparator_standby, pin_latch_hold, pin_force_reset, periodic_wake_osc_run, partial_powerdown_flag;
  logic illegal_opcode_reset, power_on_restart, system_reset, peripheral_reset, cpu_wake, external_irq;
  logic keypad_irq, periodic_wake_irq, debug_status_error, enter_active_debug;
  logic [9:0] seen = '0;
  logic seen_clr = 1'b0;
  int err_total = 0;
  int cmp_count = 0;

  initial
  begin
    forever #(CLK_NS/2) clk = ~clk;
  end

  smpc_stop_ctrl #(.WAKE_TICK_CYCLES(4)) dut_u (
    .clk, .rst_n, .stop_exec, .stop_allow, .powerdown_select, .partial_powerdown_select, .lowvolt_reset_enable,
    .debug_mode_enable, .partial_powerdown_ack, .periodic_wake_rate_select, .reset_pin_n, .external_request_pin,
    .external_request_enable, .external_request_active_high, .keypad_wake_group_a, .keypad_group_a_enable,
    .keypad_wake_group_b, .keypad_group_b_enable, .keypad_active_high, .debug_status_command, .debug_halt_command,
    .stop_state, .core_power_on, .ram_power_on, .regulator_standby, .oscillator_run, .debug_clock_run,
    .peripheral_clock_run, .analog_comparator_standby, .pin_latch_hold, .pin_force_reset, .periodic_wake_osc_run,
    .partial_powerdown_flag, .illegal_opcode_reset, .power_on_restart, .system_reset, .peripheral_reset, .cpu_wake,
    .external_irq, .keypad_irq, .periodic_wake_irq, .debug_status_error, .enter_active_debug);

  smpc_sw_model #(.RESTORE_CYCLES(5)) sw_u (
    .clk, .partial_powerdown_flag, .pull_ext, .pull_kba, .pull_kbb, .pull_rst, .reset_pin_n,
    .external_request_pin, .keypad_wake_group_a, .keypad_wake_group_b, .partial_powerdown_ack);

  ////////////////////////////////////////////////////////////
  // one-cycle pulses are caught here so no sampling slot is missed
  always @(posedge clk)
    seen <= seen_clr ? 10'h000 : seen | {illegal_opcode_reset, power_on_restart, system_reset, peripheral_reset,
                    cpu_wake, external_irq, keypad_irq, periodic_wake_irq, debug_status_error, enter_active_debug};

  function automatic logic [7:0] pw();
    return {core_power_on, ram_power_on, regulator_standby, oscillator_run, peripheral_clock_run,
            analog_comparator_standby, pin_latch_hold, pin_force_reset};
  endfunction : pw

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic wait_mode(input logic [1:0] m, input int n);
    for (int i = 0; i < n && stop_state !== m; i++) @(negedge clk);
    chk(stop_state, m);
  endtask : wait_mode

  // extra cycle lets the wake pulses reach the sticky vector
  task automatic wake_run(input int n);
    wait_mode(2'b00, n);
    cyc(1);
  endtask : wake_run

  // gap first: released pins need the synchronisers to clear
  task automatic do_stop(input logic al, pd, ppd, lowvolt_detect, dbg, input logic [1:0] m);
    cyc(4);
    stop_allow = al;
    powerdown_select = pd;
    partial_powerdown_select = ppd;
    lowvolt_reset_enable = lowvolt_detect;
    debug_mode_enable = dbg;
    seen_clr = 1'b1;
    stop_exec = 1'b1;
    cyc(1);
    stop_exec = 1'b0;
    seen_clr = 1'b0;
    wait_mode(m, 4);
  endtask : do_stop

  ////////////////////////////////////////////////////////////
  task automatic t_stop2();
    external_request_active_high = 1'b1;
    do_stop(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'b10);
    chk(pw(), 8'h66);
    pull_kbb = 1'b1;
    cyc(10);
    chk(stop_state, 2'b10);
    pull_kbb = 1'b0;
    pull_ext = 1'b1;
    wake_run(10);
    pull_ext = 1'b0;
    external_request_active_high = 1'b0;
    chk({seen[8], seen[6], partial_powerdown_flag, pin_latch_hold, core_power_on}, 5'h1f);
    cyc(12);
    chk({partial_powerdown_flag, pin_latch_hold}, 2'b00);
    $display("test stop2 done");
  endtask : t_stop2

  task automatic t_stop1();
    do_stop(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'b01);
    chk(pw(), 8'h25);
    pull_kba = 1'b1;
    wake_run(10);
    pull_kba = 1'b0;
    chk({seen & 10'h140, partial_powerdown_flag}, {10'h140, 1'b0});
    $display("test stop1 done");
  endtask : t_stop1

  task automatic t_lvd();
    do_stop(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'b11);
    chk(pw(), 8'hd4);
    pull_ext = 1'b1;
    pull_kbb = 1'b1;
    wake_run(10);
    pull_ext = 1'b0;
    pull_kbb = 1'b0;
    chk(seen & 10'h1f8, 10'h038);
    $display("test lowvolt done");
  endtask : t_lvd

  task automatic t_debug();
    do_stop(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 2'b11);
    chk({debug_clock_run, pw()}, 9'h1d4);
    debug_status_command = 1'b1;
    cyc(1);
    debug_status_command = 1'b0;
    cyc(2);
    chk(seen & 10'h002, 10'h002);
    debug_halt_command = 1'b1;
    cyc(1);
    debug_halt_command = 1'b0;
    wake_run(6);
    chk(seen & 10'h021, 10'h001);
    $display("test debug done");
  endtask : t_debug

  task automatic t_illegal();
    do_stop(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 2'b00);
    cyc(2);
    chk({stop_state, seen[9]}, 3'b001);
    $display("test illegal done");
  endtask : t_illegal

  task automatic t_stop3();
    do_stop(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'b11);
    chk({debug_clock_run, pw()}, 9'h0e4);
    cyc(40);
    chk({stop_state, periodic_wake_osc_run}, 3'b110);
    pull_rst = 1'b1;
    wake_run(10);
    pull_rst = 1'b0;
    chk(seen & 10'h0a0, 10'h080);
    do_stop(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'b11);
    periodic_wake_rate_select = 3'h1;
    cyc(1);
    chk(periodic_wake_osc_run, 1'b1);
    wake_run(40);
    periodic_wake_rate_select = RATE_OFF;
    chk(seen & 10'h1e4, 10'h024);
    $display("test stop3 done");
  endtask : t_stop3

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////
  initial
  begin
    cyc(10);
    rst_n = 1'b1;
    cyc(2);
    chk({stop_state, partial_powerdown_flag, pin_latch_hold, pw()}, 12'h0d8);
    t_stop2();
    t_stop1();
    t_lvd();
    t_debug();
    t_illegal();
    t_stop3();
    complete_run();
  end

  initial
  begin
    #(CLK_NS * WD_CYCLES);
    err_total++;
    complete_run();
  end
endmodule : smpc_stop_ctrl_tb

/* bench/smpc_sw_model.sv */
// Purpose: behavioural software and wake-pin side of the stop controller
// Assumes: pull controls change on the falling edge of clk
// Notes:   wake pins have pull-ups; the ack follows a restore delay
`timescale 1ns/1ps

module smpc_sw_model
  import smpc_pkg::*;
#(
  parameter int RESTORE_CYCLES = 5
)
(
  input  wire logic       clk,
  input  wire logic       partial_powerdown_flag,
  input  wire logic       pull_ext,
  input  wire logic       pull_kba,
  input  wire logic       pull_kbb,
  input  wire logic       pull_rst,
  output logic            reset_pin_n,
  output logic            external_request_pin,
  output logic [KB_W-1:0] keypad_wake_group_a,
  output logic [KB_W-1:0] keypad_wake_group_b,
  output logic            partial_powerdown_ack
);
  int wait_cnt = 0;

  ////////////////////////////////////////////////////////////
  // released pins go back to their pull-up level
  assign reset_pin_n          = !pull_rst;
  assign external_request_pin = !pull_ext;
  assign keypad_wake_group_a  = pull_kba ? 8'hfe : KB_IDLE;
  assign keypad_wake_group_b  = pull_kbb ? 8'hfe : KB_IDLE;

  ////////////////////////////////////////////////////////////
  // ports are copied back from ram before the ack is written
  initial partial_powerdown_ack = 1'b0;
  always @(negedge clk)
  begin
    partial_powerdown_ack <= 1'b0;
    if (partial_powerdown_flag !== 1'b1)
      wait_cnt <= 0;
    else if (wait_cnt == RESTORE_CYCLES)
    begin
      partial_powerdown_ack <= 1'b1;
      wait_cnt              <= 0;
    end
    else
      wait_cnt <= wait_cnt + 1;
  end
endmodule : smpc_sw_model

/* hw/smpc_pkg.sv */
// Purpose: shared types and constants of the stop-mode power controller
// Assumes: 25 MHz system clock
// Notes:   mode codes, synchroniser idle levels, periodic wake timing
package smpc_pkg;

  typedef enum logic [1:0]
  {
    SMPC_RUN   = 2'b00,
    SMPC_STOP1 = 2'b01,
    SMPC_STOP2 = 2'b10,
    SMPC_STOP3 = 2'b11
  } smpc_mode_type;

  localparam int KB_W        = 8;
  localparam int RATE_W      = 3;
  localparam int PRESCALE_W  = 16;
  localparam int TICK_W      = 8;

  localparam int CLK_PERIOD_NS       = 40;
  localparam int WAKE_SRC_PERIOD_NS  = 1_000_000;
  localparam int WAKE_SRC_CYCLES     = WAKE_SRC_PERIOD_NS / CLK_PERIOD_NS;

  localparam logic [RATE_W-1:0] RATE_OFF = 3'h0;
  localparam logic              PIN_IDLE = 1'b1;
  localparam logic [KB_W-1:0]   KB_IDLE  = 8'hff;

  typedef struct packed
  {
    logic                  ext_meta;
    logic                  ext_sync;
    logic                  rpin_meta;
    logic                  rpin_sync;
    logic [KB_W-1:0]       kba_meta;
    logic [KB_W-1:0]       kba_sync;
    logic [KB_W-1:0]       kbb_meta;
    logic [KB_W-1:0]       kbb_sync;
    smpc_mode_type         mode;
    logic                  reg_full;
    logic                  dbg_keep;
    logic [PRESCALE_W-1:0] prescale;
    logic [TICK_W-1:0]     ticks;
    logic                  core_power_on;
    logic                  ram_power_on;
    logic                  regulator_standby;
    logic                  oscillator_run;
    logic                  debug_clock_run;
    logic                  peripheral_clock_run;
    logic                  analog_comparator_standby;
    logic                  pin_latch_hold;
    logic                  pin_force_reset;
    logic                  periodic_wake_osc_run;
    logic                  partial_powerdown_flag;
    logic                  illegal_opcode_reset;
    logic                  power_on_restart;
    logic                  system_reset;
    logic                  peripheral_reset;
    logic                  cpu_wake;
    logic                  external_irq;
    logic                  keypad_irq;
    logic                  periodic_wake_irq;
    logic                  debug_status_error;
    logic                  enter_active_debug;
  } smpc_state_type;

  localparam smpc_state_type SMPC_STATE_RST = '{
    ext_meta: PIN_IDLE, ext_sync: PIN_IDLE, rpin_meta: PIN_IDLE, rpin_sync: PIN_IDLE,
    kba_meta: KB_IDLE, kba_sync: KB_IDLE, kbb_meta: KB_IDLE, kbb_sync: KB_IDLE,
    mode: SMPC_RUN, prescale: 16'h0000, ticks: 8'h00,
    core_power_on: 1'b1, ram_power_on: 1'b1, oscillator_run: 1'b1, debug_clock_run: 1'b1,
    peripheral_clock_run: 1'b1,
    default: 1'b0};

endpackage : smpc_pkg

/* hw/smpc_stop_ctrl.sv */
// Purpose: stop-depth selection, pin latching, wake-up sourcing and power gating
// Assumes: inputs synchronous to clk except wake pins, which are resynchronised
// Notes:   one state struct, one always_comb, two always_ff (reset release and state)
`timescale 1ns/1ps

module smpc_stop_ctrl
  import smpc_pkg::*;
#(
  parameter int WAKE_TICK_CYCLES = WAKE_SRC_CYCLES
)
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              stop_exec,
  input  wire logic              stop_allow,
  input  wire logic              powerdown_select,
  input  wire logic              partial_powerdown_select,
  input  wire logic              lowvolt_reset_enable,
  input  wire logic              debug_mode_enable,
  input  wire logic              partial_powerdown_ack,
  input  wire logic [RATE_W-1:0] periodic_wake_rate_select,
  input  wire logic              reset_pin_n,
  input  wire logic              external_request_pin,
  input  wire logic              external_request_enable,
  input  wire logic              external_request_active_high,
  input  wire logic [KB_W-1:0]   keypad_wake_group_a,
  input  wire logic [KB_W-1:0]   keypad_group_a_enable,
  input  wire logic [KB_W-1:0]   keypad_wake_group_b,
  input  wire logic [KB_W-1:0]   keypad_group_b_enable,
  input  wire logic              keypad_active_high,
  input  wire logic              debug_status_command,
  input  wire logic              debug_halt_command,
  output logic [1:0]             stop_state,
  output logic                   core_power_on,
  output logic                   ram_power_on,
  output logic                   regulator_standby,
  output logic                   oscillator_run,
  output logic                   debug_clock_run,
  output logic                   peripheral_clock_run,
  output logic                   analog_comparator_standby,
  output logic                   pin_latch_hold,
  output logic                   pin_force_reset,
  output logic                   periodic_wake_osc_run,
  output logic                   partial_powerdown_flag,
  output logic                   illegal_opcode_reset,
  output logic                   power_on_restart,
  output logic                   system_reset,
  output logic                   peripheral_reset,
  output logic                   cpu_wake,
  output logic                   external_irq,
  output logic                   keypad_irq,
  output logic                   periodic_wake_irq,
  output logic                   debug_status_error,
  output logic                   enter_active_debug
);

  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(WAKE_TICK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic           rst_meta_n;
  logic           rst_sync_n;
  smpc_state_type s;
  smpc_state_type next_s;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic              ext_low, ext_assert, rpin_low, kba_low, kb3_assert, wake_osc_on, rti_fire;
  logic [TICK_W-1:0] tick_target;
  logic [KB_W-1:0]   kba_level, kbb_level;

  always_comb
  begin
    next_s = s;
    {next_s.illegal_opcode_reset, next_s.power_on_restart, next_s.system_reset, next_s.peripheral_reset,
     next_s.cpu_wake, next_s.external_irq, next_s.keypad_irq, next_s.periodic_wake_irq,
     next_s.debug_status_error, next_s.enter_active_debug} = 10'h000;

    // two-stage synchronisers; only the second stage is looked at
    next_s.ext_meta  = external_request_pin;
    next_s.ext_sync  = s.ext_meta;
    next_s.rpin_meta = reset_pin_n;
    next_s.rpin_sync = s.rpin_meta;
    next_s.kba_meta  = keypad_wake_group_a;
    next_s.kba_sync  = s.kba_meta;
    next_s.kbb_meta  = keypad_wake_group_b;
    next_s.kbb_sync  = s.kbb_meta;

    // deep stop ignores configured polarity
    rpin_low   = !s.rpin_sync;
    ext_low    = external_request_enable && !s.ext_sync;
    kba_low    = |(keypad_group_a_enable & ~s.kba_sync);
    ext_assert = external_request_enable &&
                 (external_request_active_high ? s.ext_sync : !s.ext_sync);
    kba_level  = keypad_active_high ? s.kba_sync : ~s.kba_sync;
    kbb_level  = keypad_active_high ? s.kbb_sync : ~s.kbb_sync;
    kb3_assert = |(keypad_group_a_enable & kba_level) ||
                 |(keypad_group_b_enable & kbb_level);

    // periodic wake: 1 kHz ticks, interval of 2^(rate-1) ticks
    wake_osc_on = (periodic_wake_rate_select != RATE_OFF) && (s.mode != SMPC_STOP1);
    tick_target = TICK_W'(8'h01 << (periodic_wake_rate_select - 3'h1));
    rti_fire    = wake_osc_on && (s.prescale == PRESCALE_LAST) &&
                  (s.ticks == tick_target - 8'h01);
    if (!wake_osc_on)
    begin
      next_s.prescale = 16'h0000;
      next_s.ticks    = 8'h00;
    end
    else if (s.prescale != PRESCALE_LAST)
    begin
      next_s.prescale = s.prescale + 16'h0001;
    end
    else
    begin
      next_s.prescale = 16'h0000;
      next_s.ticks    = rti_fire ? 8'h00 : s.ticks + 8'h01;
    end

    // acknowledge opens latches; wake in the same cycle still wins below
    if (partial_powerdown_ack)
    begin
      next_s.pin_latch_hold         = 1'b0;
      next_s.partial_powerdown_flag = 1'b0;
    end

    if ((s.mode != SMPC_RUN) && debug_status_command)
    begin
      next_s.debug_status_error = 1'b1;
    end

    case (s.mode)
      SMPC_RUN:
      begin
        next_s.periodic_wake_irq = rti_fire;
        if (stop_exec && !stop_allow)
        begin
          next_s.illegal_opcode_reset = 1'b1;
        end
        else if (stop_exec)
        begin
          next_s.reg_full = lowvolt_reset_enable || debug_mode_enable;
          next_s.dbg_keep = debug_mode_enable;
          if (lowvolt_reset_enable || debug_mode_enable || !powerdown_select)
          begin
            next_s.mode = SMPC_STOP3;
          end
          else if (partial_powerdown_select)
          begin
            next_s.mode           = SMPC_STOP2;
            next_s.pin_latch_hold = 1'b1;
          end
          else
          begin
            next_s.mode = SMPC_STOP1;
          end
        end
      end
      SMPC_STOP1:
      begin
        if (rpin_low || ext_low || kba_low)
        begin
          next_s.mode             = SMPC_RUN;
          next_s.power_on_restart = 1'b1;
          next_s.peripheral_reset = 1'b1;
        end
      end
      SMPC_STOP2:
      begin
        // group B deliberately absent
        if (rpin_low || ext_low || kba_low || rti_fire)
        begin
          next_s.mode                   = SMPC_RUN;
          next_s.power_on_restart       = 1'b1;
          next_s.peripheral_reset       = 1'b1;
          next_s.pin_latch_hold         = 1'b1;
          next_s.partial_powerdown_flag = 1'b1;
        end
      end
      SMPC_STOP3:
      begin
        if (rpin_low)
        begin
          next_s.mode         = SMPC_RUN;
          next_s.system_reset = 1'b1;
        end
        else if (debug_halt_command && s.dbg_keep)
        begin
          next_s.mode               = SMPC_RUN;
          next_s.enter_active_debug = 1'b1;
        end
        else if (ext_assert || kb3_assert || rti_fire)
        begin
          next_s.mode              = SMPC_RUN;
          next_s.cpu_wake          = 1'b1;
          next_s.external_irq      = ext_assert;
          next_s.keypad_irq        = kb3_assert;
          next_s.periodic_wake_irq = rti_fire;
        end
      end
      default:
      begin
        next_s.mode = SMPC_RUN;
      end
    endcase

    if (next_s.mode == SMPC_RUN)
    begin
      next_s.reg_full = 1'b0;
      next_s.dbg_keep = 1'b0;
    end

    // power and clock controls follow the mode being entered
    next_s.core_power_on             = (next_s.mode == SMPC_RUN) || (next_s.mode == SMPC_STOP3);
    next_s.ram_power_on              = (next_s.mode != SMPC_STOP1);
    next_s.regulator_standby         = (next_s.mode != SMPC_RUN) && !next_s.reg_full;
    next_s.oscillator_run            = (next_s.mode == SMPC_RUN) || next_s.reg_full;
    next_s.debug_clock_run           = (next_s.mode == SMPC_RUN) || next_s.dbg_keep;
    next_s.peripheral_clock_run      = (next_s.mode == SMPC_RUN);
    next_s.analog_comparator_standby = (next_s.mode != SMPC_RUN);
    next_s.pin_force_reset           = (next_s.mode == SMPC_STOP1);
    next_s.periodic_wake_osc_run     = (periodic_wake_rate_select != RATE_OFF) &&
                                       (next_s.mode != SMPC_STOP1);
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      s <= SMPC_STATE_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign stop_state = s.mode;
  assign {core_power_on, ram_power_on, regulator_standby, oscillator_run, debug_clock_run,
          peripheral_clock_run, analog_comparator_standby, pin_latch_hold, pin_force_reset,
          periodic_wake_osc_run, partial_powerdown_flag, illegal_opcode_reset, power_on_restart,
          system_reset, peripheral_reset, cpu_wake, external_irq, keypad_irq, periodic_wake_irq,
          debug_status_error, enter_active_debug}
    = {s.core_power_on, s.ram_power_on, s.regulator_standby, s.oscillator_run, s.debug_clock_run,
       s.peripheral_clock_run, s.analog_comparator_standby, s.pin_latch_hold, s.pin_force_reset,
       s.periodic_wake_osc_run, s.partial_powerdown_flag, s.illegal_opcode_reset, s.power_on_restart,
       s.system_reset, s.peripheral_reset, s.cpu_wake, s.external_irq, s.keypad_irq,
       s.periodic_wake_irq, s.debug_status_error, s.enter_active_debug};

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  a_stop2_entry: assert property ((s.mode == SMPC_RUN) && stop_exec && stop_allow && powerdown_select &&
    partial_powerdown_select && !lowvolt_reset_enable && !debug_mode_enable
    |=> (s.mode == SMPC_STOP2) && pin_latch_hold)
    else $error("stop2 not entered");
  a_lvd_forces_stop3: assert property ((s.mode == SMPC_RUN) && stop_exec && stop_allow && lowvolt_reset_enable
    |=> (s.mode == SMPC_STOP3) && !regulator_standby && oscillator_run)
    else $error("low-voltage reset enable did not force stop3");
  a_stop1_select: assert property ((s.mode == SMPC_RUN) && stop_exec && stop_allow && powerdown_select &&
    !partial_powerdown_select && !lowvolt_reset_enable && !debug_mode_enable
    |=> (s.mode == SMPC_STOP1) && pin_force_reset && !ram_power_on)
    else $error("stop1 not entered");
  a_latch_held: assert property (pin_latch_hold && !partial_powerdown_ack |=> pin_latch_hold)
    else $error("pin latch released without acknowledge");
  a_stop2_restart: assert property ((s.mode == SMPC_STOP2) ##1 (s.mode == SMPC_RUN)
    |-> power_on_restart && pin_latch_hold && partial_powerdown_flag)
    else $error("stop2 wake not a restart with latched pins and flag");
  a_no_group_b_wake: assert property ((s.mode == SMPC_STOP2) && s.rpin_sync &&
    !(external_request_enable && !s.ext_sync) && ((keypad_group_a_enable & ~s.kba_sync) == 8'h00) && !rti_fire
    |=> (s.mode == SMPC_STOP2))
    else $error("stop2 left without a valid wake source");
  a_illegal_stop: assert property ((s.mode == SMPC_RUN) && stop_exec && !stop_allow
    |=> illegal_opcode_reset && (s.mode == SMPC_RUN) ##1 !illegal_opcode_reset)
    else $error("illegal stop not turned into a reset pulse");
  a_debug_keeps_clock: assert property ((s.mode == SMPC_RUN) && stop_exec && stop_allow && debug_mode_enable
    |=> (s.mode == SMPC_STOP3) && debug_clock_run && !peripheral_clock_run)
    else $error("debug enable did not hold stop3 with debug clock");
  a_stop_gating: assert property ((s.mode != SMPC_RUN) |-> !peripheral_clock_run && analog_comparator_standby)
    else $error("peripheral clock or comparator active in stop");
  a_rate_off: assert property ((periodic_wake_rate_select == RATE_OFF) [*2] |-> !periodic_wake_osc_run &&
    !periodic_wake_irq)
    else $error("periodic wake active with rate zero");
  a_flag_kept: assert property (partial_powerdown_flag && !partial_powerdown_ack |=> partial_powerdown_flag)
    else $error("flag dropped without acknowledge");

endmodule : smpc_stop_ctrl
